// ===== hw/apr_active_power.sv
// Active power path from current and voltage samples to energy pulse outputs
// How it works
// - High-pass current samples to strip dc
// - Multiply filtered current by matching voltage sample
// - Low-pass the product to get active power
// - Power low-pass is single pole near 4.5 Hz
// - Match high-pass phase in the voltage channel
// - Accumulate active power into pulse rate
// - Slow outputs use long accumulation between pulses
// - Calibration output accumulates over much shorter period
// - Rate selects pick oscillator over 2^18..2^15
// - Scale and rate selects set ratio 16..2048
// - Slow outputs are active-high pulses
// - Current gain one or sixteen from pin
`timescale 1ns/100ps
module apr_active_power #(
  parameter int FIFO_DEPTH = 16,
  parameter int SLOW_PULSE_CYC = apr_pkg::SLOW_PULSE_CYC,
  parameter int CF_PULSE_CYC = apr_pkg::CF_PULSE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sample_valid,
  input wire apr_pkg::apr_sample_t sample,
  output logic sample_ready,
  input wire logic rate_select_low,
  input wire logic rate_select_high,
  input wire logic calibration_scale_select,
  input wire logic current_gain_select,
  output logic energy_pulse_out_a,
  output logic energy_pulse_out_b,
  output logic calibration_pulse_out
);
  localparam int DW = apr_pkg::DW;
  localparam int CW = DW + 1 + apr_pkg::GAIN_SHIFT;
  localparam int PW = CW + DW + 1;
  localparam int AW = PW + apr_pkg::BASE_EXP_MAX + 2;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int SCW = $clog2(SLOW_PULSE_CYC + 1);
  localparam int FCW = $clog2(CF_PULSE_CYC + 1);

  // Select pins come from outside and pass two flops first
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {current_gain_select, calibration_scale_select, rate_select_high, rate_select_low};
      pin_sync <= pin_meta;
    end
  end

  apr_pkg::apr_sel_t sel;
  wire logic gain16 = pin_sync[3];
  assign sel = '{scale: pin_sync[2], high: pin_sync[1], low: pin_sync[0]};

  // Control register, run bit enables draining of the sample FIFO
  logic [31:0] ctrl;
  wire logic run = ctrl[apr_pkg::CTRL_RUN_BIT];
  logic cnt_clear;

  // Sample FIFO; a stopped path lets it fill and drop sample_ready
  apr_pkg::apr_sample_t fifo_out;
  logic fifo_valid;
  logic [LW-1:0] fifo_level;
  wire logic pop = fifo_valid && run;
  apr_fifo #(.WIDTH($bits(apr_pkg::apr_sample_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .s_valid(sample_valid),
    .s_ready(sample_ready),
    .s_data(sample),
    .m_valid(fifo_valid),
    .m_ready(run),
    .m_data(fifo_out),
    .level(fifo_level)
  );

  // Current dc removal, voltage through an identical section so phases match
  logic hp_valid;
  logic signed [DW:0] cur_hp;
  logic signed [DW:0] volt_hp;
  apr_one_pole #(.W(DW), .SHIFT(apr_pkg::HPF_SHIFT)) u_hpf_cur (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(pop),
    .x(fifo_out.cur),
    .out_valid(hp_valid),
    .lp(),
    .hp(cur_hp)
  );
  apr_one_pole #(.W(DW), .SHIFT(apr_pkg::HPF_SHIFT)) u_hpf_volt (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(pop),
    .x(fifo_out.volt),
    .out_valid(),
    .lp(),
    .hp(volt_hp)
  );

  // Gain of 16 is a left shift; headroom is in CW so nothing wraps
  wire logic signed [CW-1:0] cur_scaled = gain16 ? (CW'(cur_hp) <<< apr_pkg::GAIN_SHIFT) : CW'(cur_hp);
  wire logic signed [PW-1:0] next_prod = PW'(cur_scaled) * PW'(volt_hp);

  logic prod_valid;
  logic signed [PW-1:0] prod;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prod_valid <= 1'b0;
      prod <= '0;
    end else begin
      prod_valid <= hp_valid;
      if (hp_valid) prod <= next_prod;
    end
  end

  // Single-pole low-pass extracts the dc term of the product
  logic lpf_valid;
  logic signed [PW-1:0] act_pwr;
  apr_one_pole #(.W(PW), .SHIFT(apr_pkg::LPF_SHIFT)) u_lpf (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(prod_valid),
    .x(prod),
    .out_valid(lpf_valid),
    .lp(act_pwr),
    .hp()
  );

  // Reverse power is not billed, so it adds nothing
  wire logic [AW-1:0] pwr_pos = act_pwr[PW-1] ? '0 : AW'(act_pwr);

  // Thresholds: slow at full scale times 2^n, calibration smaller by the ratio
  wire logic [6:0] slow_exp = 7'(apr_pkg::PWR_FS_EXP) + apr_pkg::base_exp(sel);
  wire logic [6:0] cf_exp = slow_exp - apr_pkg::ratio_log2(sel);
  wire logic [AW-1:0] thr_slow = AW'(1) << slow_exp;
  wire logic [AW-1:0] thr_cf = AW'(1) << cf_exp;

  logic [AW-1:0] acc_slow;
  logic [AW-1:0] acc_cf;
  wire logic [AW-1:0] next_acc_slow = acc_slow + pwr_pos;
  wire logic [AW-1:0] next_acc_cf = acc_cf + pwr_pos;
  wire logic fire_slow = lpf_valid && (next_acc_slow >= thr_slow);
  wire logic fire_cf = lpf_valid && (next_acc_cf >= thr_cf);

  // Crossing subtracts the threshold so the residue carries to the next pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_slow <= '0;
      acc_cf <= '0;
    end else if (lpf_valid) begin
      acc_slow <= fire_slow ? next_acc_slow - thr_slow : next_acc_slow;
      acc_cf <= fire_cf ? next_acc_cf - thr_cf : next_acc_cf;
    end
  end

  // Slow pulses alternate between the two outputs, as a stepper drive needs
  logic slow_to_b;
  logic [SCW-1:0] slow_cnt_a;
  logic [SCW-1:0] slow_cnt_b;
  logic [FCW-1:0] cf_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_to_b <= 1'b0;
      slow_cnt_a <= '0;
      slow_cnt_b <= '0;
      cf_cnt <= '0;
    end else begin
      if (fire_slow) slow_to_b <= !slow_to_b;
      if (fire_slow && !slow_to_b) slow_cnt_a <= SCW'(SLOW_PULSE_CYC);
      else if (slow_cnt_a != '0) slow_cnt_a <= slow_cnt_a - 1'b1;
      if (fire_slow && slow_to_b) slow_cnt_b <= SCW'(SLOW_PULSE_CYC);
      else if (slow_cnt_b != '0) slow_cnt_b <= slow_cnt_b - 1'b1;
      if (fire_cf) cf_cnt <= FCW'(CF_PULSE_CYC);
      else if (cf_cnt != '0) cf_cnt <= cf_cnt - 1'b1;
    end
  end

  // Outputs are decodes of flop counters, high while a count runs
  assign energy_pulse_out_a = slow_cnt_a != '0;
  assign energy_pulse_out_b = slow_cnt_b != '0;
  assign calibration_pulse_out = cf_cnt != '0;

  // Pulse tallies for software; a pulse in the clear cycle still counts
  logic [31:0] slow_total;
  logic [31:0] cf_total;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_total <= 32'h0000_0000;
      cf_total <= 32'h0000_0000;
    end else begin
      slow_total <= (cnt_clear ? 32'h0000_0000 : slow_total) + 32'(fire_slow);
      cf_total <= (cnt_clear ? 32'h0000_0000 : cf_total) + 32'(fire_cf);
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  apr_pkg::apr_ahb_req_t req;
  wire logic addr_ok = haddr[31:8] == 24'h00_0000;
  wire logic take = hsel && hready && (htrans == apr_pkg::HTRANS_NONSEQ || htrans == 2'h3);
  wire logic [31:0] status_word = (32'(sel) << apr_pkg::STAT_SEL_LSB)
                                | (32'(gain16) << apr_pkg::STAT_GAIN_BIT)
                                | (32'(fifo_level) << apr_pkg::STAT_LEVEL_LSB);
  wire logic [31:0] power_word = act_pwr[PW-1:PW-32];
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      unique case (haddr[7:0])
        apr_pkg::REG_CTRL: rd_mux = ctrl;
        apr_pkg::REG_STATUS: rd_mux = status_word;
        apr_pkg::REG_POWER: rd_mux = power_word;
        apr_pkg::REG_SLOW_CNT: rd_mux = slow_total;
        apr_pkg::REG_CF_CNT: rd_mux = cf_total;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire logic wr_ctrl = req.act && req.write && req.addr == apr_pkg::REG_CTRL;
  assign cnt_clear = wr_ctrl && hwdata[apr_pkg::CTRL_CLR_BIT];

  // Address phase is latched; read data is loaded then so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      hrdata <= 32'h0000_0000;
      ctrl <= apr_pkg::CTRL_RESET;
    end else begin
      req.act <= take && addr_ok;
      req.write <= hwrite;
      req.addr <= haddr[7:0];
      if (take && !hwrite) hrdata <= rd_mux;
      if (wr_ctrl) ctrl <= {31'h0000_0000, hwdata[apr_pkg::CTRL_RUN_BIT]};
    end
  end

  AST_POP_NEEDS_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
    pop |-> run && fifo_valid) else $error("sample popped while stopped");
  AST_HPF_FOLLOWS_POP: assert property (@(posedge hclk) disable iff (!hresetn)
    pop |=> hp_valid ##1 prod_valid) else $error("filter stage missed a sample");
  AST_PRODUCT_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
    hp_valid |=> prod == PW'($past(cur_scaled)) * PW'($past(volt_hp))) else $error("product wrong");
  AST_GAIN_SCALE: assert property (@(posedge hclk) disable iff (!hresetn)
    hp_valid && gain16 |-> cur_scaled == CW'(cur_hp) * 16) else $error("gain of 16 not applied");
  AST_LPF_FOLLOWS_PROD: assert property (@(posedge hclk) disable iff (!hresetn)
    prod_valid |=> lpf_valid) else $error("low-pass missed a product");
  AST_ACC_RESIDUE: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_cf |=> acc_cf == $past(acc_cf) + $past(pwr_pos) - $past(thr_cf)) else $error("residue lost");
  AST_ACC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !lpf_valid |=> $stable(acc_slow) && $stable(acc_cf)) else $error("accumulator moved without sample");
  AST_SLOW_BASE: assert property (@(posedge hclk) disable iff (!hresetn)
    !sel.high && !sel.low |-> thr_slow == AW'(1) << 64) else $error("slow base not 2^18");
  AST_CF_RATIO_MAX: assert property (@(posedge hclk) disable iff (!hresetn)
    !sel.scale && sel.high && sel.low |-> thr_slow == thr_cf << 11) else $error("ratio not 2048");
  AST_SLOW_PULSE_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_slow && !slow_to_b |=> energy_pulse_out_a [*8]) else $error("slow pulse too short");
  AST_SLOW_ALTERNATE: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_slow |=> slow_to_b != $past(slow_to_b)) else $error("slow outputs did not alternate");
  AST_CF_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_cf |=> calibration_pulse_out [*4]) else $error("calibration pulse missing");
  AST_CLEAR_KEEPS_EVENT: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_clear |=> cf_total == 32'($past(fire_cf))) else $error("clear lost a pulse");
  AST_READ_NEXT: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && addr_ok && haddr[7:0] == apr_pkg::REG_CTRL |=> hrdata == $past(ctrl))
    else $error("control readback wrong");


  // Bus side: zero wait states and OKAY keep any master from stalling
  AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
  AST_CTRL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> ctrl == {31'h0000_0000, $past(hwdata[apr_pkg::CTRL_RUN_BIT])})
    else $error("control write lost");
  AST_UNMAPPED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && !addr_ok |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  // Stream side: the source only sees a refusal once all sixteen words are held
  AST_READY_FULL: assert property (@(posedge hclk) disable iff (!hresetn)
    !sample_ready |-> fifo_level == LW'(FIFO_DEPTH)) else $error("refused before full");
  AST_HP_NEEDS_POP: assert property (@(posedge hclk) disable iff (!hresetn)
    hp_valid |-> $past(pop)) else $error("filter output without a sample");
  AST_GAIN_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
    hp_valid && !gain16 |-> cur_scaled == CW'(cur_hp)) else $error("gain of one altered sample");

  // Threshold table; a wrong exponent shifts every pulse rate by a power of two
  AST_BASE_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
    sel.high && sel.low |-> thr_slow == (AW'(1) << 61)) else $error("slow base not 2^15");
  AST_BASE_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    sel.high && !sel.low |-> thr_slow == (AW'(1) << 62)) else $error("slow base not 2^16");
  AST_RATIO_128: assert property (@(posedge hclk) disable iff (!hresetn)
    sel.scale && !sel.high && !sel.low |-> thr_slow == (thr_cf << 7)) else $error("ratio not 128");
  AST_RATIO_16: assert property (@(posedge hclk) disable iff (!hresetn)
    sel.high && (sel.scale == sel.low) |-> thr_slow == (thr_cf << 4)) else $error("ratio not 16");
  AST_CF_FASTER: assert property (@(posedge hclk) disable iff (!hresetn)
    thr_cf < thr_slow) else $error("calibration threshold not below slow");

  // Reverse power must never move an accumulator upward
  AST_REVERSE_NO_ADD: assert property (@(posedge hclk) disable iff (!hresetn)
    lpf_valid && act_pwr[PW-1] |=> acc_slow <= $past(acc_slow) && acc_cf <= $past(acc_cf))
    else $error("reverse power accumulated");
  // Tallies step by one per fire when no clear is pending
  AST_TALLY_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !cnt_clear |=> cf_total == $past(cf_total) + 32'($past(fire_cf))) else $error("tally step wrong");

  COV_CLEAR: cover property (@(posedge hclk) disable iff (!hresetn) cnt_clear);
  COV_SLOW_PULSE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(energy_pulse_out_b));
  COV_CF_PULSE: cover property (@(posedge hclk) disable iff (!hresetn) fire_cf ##[1:1000] fire_cf);
  COV_FIFO_FULL: cover property (@(posedge hclk) disable iff (!hresetn) !sample_ready);
  COV_GAIN16: cover property (@(posedge hclk) disable iff (!hresetn) fire_cf && gain16);
endmodule

// ===== hw/apr_pkg.sv
// Shared constants, carriers and helpers of the active power to pulse rate block
package apr_pkg;
  // Sample and arithmetic widths
  localparam int DW = 24;
  localparam int GAIN_SHIFT = 4;
  localparam int HPF_SHIFT = 12;
  // Pole at fs / (2*pi*2^14), about 4.4 Hz with a 450 kHz sample rate
  localparam int LPF_SHIFT = 14;
  localparam int LPF_CORNER_MHZ = 4500;
  localparam int OSC_HZ = 450000;
  // Full-scale product exponent and the base divide exponents 18 down to 15
  localparam int PWR_FS_EXP = 2 * DW - 2;
  localparam int BASE_EXP_MAX = 18;
  // Pulse widths on the outputs
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SLOW_PULSE_NS = 2000;
  localparam int CF_PULSE_NS = 500;
  localparam int SLOW_PULSE_CYC = (SLOW_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int CF_PULSE_CYC = (CF_PULSE_NS * 1000) / CLK_PERIOD_PS;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POWER = 8'h08;
  localparam logic [7:0] REG_SLOW_CNT = 8'h0C;
  localparam logic [7:0] REG_CF_CNT = 8'h10;
  // Register fields and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_GAIN_BIT = 3;
  localparam int STAT_LEVEL_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic signed [DW-1:0] cur;
    logic signed [DW-1:0] volt;
  } apr_sample_t;

  typedef struct packed {
    logic scale;
    logic high;
    logic low;
  } apr_sel_t;

  typedef struct packed {
    logic act;
    logic write;
    logic [7:0] addr;
  } apr_ahb_req_t;

  // Divide exponent of the slow base rate: 18, 17, 16, 15 for codes 0..3
  function automatic logic [6:0] base_exp(input apr_sel_t s);
    base_exp = 7'(BASE_EXP_MAX) - {5'h00, s.high, s.low};
  endfunction

  // Log2 of the calibration to slow pulse ratio
  function automatic logic [6:0] ratio_log2(input apr_sel_t s);
    unique case ({s.scale, s.high, s.low})
      3'h4: ratio_log2 = 7'h07;
      3'h0, 3'h5: ratio_log2 = 7'h06;
      3'h1, 3'h6: ratio_log2 = 7'h05;
      3'h2, 3'h7: ratio_log2 = 7'h04;
      default: ratio_log2 = 7'h0B;
    endcase
  endfunction
endpackage

// ===== hw/apr_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module apr_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  // Honest full and empty from the fill level
  assign s_ready = level != (AW+1)'(DEPTH);
  assign m_valid = level != '0;
  assign m_data = mem[rd_ptr];

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= s_data;
  end

  AST_FIFO_LEVEL_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    level <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule

// ===== hw/apr_one_pole.sv
// Single-pole recursive filter giving both low-pass and high-pass outputs
`timescale 1ns/100ps
module apr_one_pole #(
  parameter int W = 24,
  parameter int SHIFT = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [W-1:0] x,
  output logic out_valid,
  output logic signed [W-1:0] lp,
  output logic signed [W:0] hp
);
  logic signed [W+SHIFT-1:0] st;
  wire logic signed [W-1:0] lp_now = st[W+SHIFT-1:SHIFT];
  // State is the average scaled by 2^SHIFT; the pole is 1 - 2^-SHIFT
  wire logic signed [W+SHIFT-1:0] next_st = st + (W+SHIFT)'(x) - (W+SHIFT)'(lp_now);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      lp <= '0;
      hp <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        st <= next_st;
        lp <= next_st[W+SHIFT-1:SHIFT];
        hp <= (W+1)'(x) - (W+1)'(lp_now);
      end
    end
  end

  AST_POLE_HP_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
    in_valid |=> hp == $past(x) - $past(lp_now)) else $error("high-pass output wrong");
endmodule

// ===== verification/apr_pulse_counter.sv
// Model of the external energy counter and calibration frequency counter
`timescale 1ns/100ps
module apr_pulse_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic pulse_cf,
  output int count_slow,
  output int count_cf,
  output int width_cf
);
  logic last_a;
  logic last_b;
  logic last_cf;
  int run_cf;

  // Counting edges over a whole run averages away ripple on the calibration rate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {last_a, last_b, last_cf} <= 3'h0;
      count_slow <= 0;
      count_cf <= 0;
      width_cf <= 0;
      run_cf <= 0;
    end else begin
      last_a <= pulse_a;
      last_b <= pulse_b;
      last_cf <= pulse_cf;
      if ((pulse_a && !last_a) || (pulse_b && !last_b)) begin
        count_slow <= count_slow + 1;
      end
      if (pulse_cf && !last_cf) begin
        count_cf <= count_cf + 1;
      end
      // Width is only known once the pulse has ended
      run_cf <= pulse_cf ? run_cf + 1 : 0;
      if (!pulse_cf && last_cf) begin
        width_cf <= run_cf;
      end
    end
  end
endmodule

// ===== verification/tb_active_power_to_pulse_rate.sv
// Self-checking bench of the active power to pulse rate block
`timescale 1ns/100ps
module tb_active_power_to_pulse_rate;
  localparam int CF_W = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sample_ready, pa, pb, pcf;
  logic [31:0] hrdata;
  logic sample_valid = 1'b0;
  apr_pkg::apr_sample_t sample = '0;
  logic [3:0] pins = 4'h0; // {gain, scale, high, low}
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int count_slow, count_cf, width_cf;
  logic [31:0] seed = 32'hEA4A;
  logic [31:0] rd, p1, p16;
  logic [23:0] va;
  logic [47:0] fifo_q[$];

  always #2.5 hclk = ~hclk;

  apr_active_power #(.SLOW_PULSE_CYC(16), .CF_PULSE_CYC(CF_W)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_valid(sample_valid), .sample(sample), .sample_ready(sample_ready),
    .rate_select_low(pins[0]), .rate_select_high(pins[1]), .calibration_scale_select(pins[2]),
    .current_gain_select(pins[3]), .energy_pulse_out_a(pa), .energy_pulse_out_b(pb),
    .calibration_pulse_out(pcf));

  apr_pulse_counter i_counter (
    .clk(hclk), .rst_n(hresetn), .pulse_a(pa), .pulse_b(pb), .pulse_cf(pcf),
    .count_slow(count_slow), .count_cf(count_cf), .width_cf(width_cf));

  // Whole run needs about 7300 cycles, so this ceiling only trips on a hang
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Range form; an unknown value never counts as inside
  task automatic chk_span(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= apr_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  // Alternating-sign samples so the dc-blocking filters pass them whole
  task automatic send(input int n, input logic [23:0] ca, input logic [23:0] vv);
    for (int i = 0; i < n; i++) begin
      sample_valid <= 1'b1;
      sample.cur <= i[0] ? -ca : ca;
      sample.volt <= i[0] ? -vv : vv;
      @(posedge hclk);
      while (sample_ready !== 1'b1) @(posedge hclk);
    end
    sample_valid <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    chk_word({29'h0, pa, pb, pcf}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    // Defaults, read-only and unmapped places
    rd_chk(32'(apr_pkg::REG_CTRL), 32'h1);
    ahb(1'b1, 32'(apr_pkg::REG_STATUS), 32'hFFFF_FFFF);
    rd_chk(32'(apr_pkg::REG_STATUS), 32'h0);
    rd_chk(32'h0000_0100, 32'h0);
    rd_chk(32'h0000_0080, 32'h0);
    $display("Test registers done");
    // Every select and gain code shows up in the status word
    for (int i = 0; i < 16; i++) begin
      pins <= i[3:0];
      repeat (2) @(posedge hclk);
      rd_chk(32'(apr_pkg::REG_STATUS), {28'h0, i[3:0]});
    end
    $display("Test selects done");
    // Stall the drain, fill until refused, then drain
    pins <= 4'h0;
    ahb(1'b1, 32'(apr_pkg::REG_CTRL), 32'h0);
    for (int i = 0; i < 20; i++) begin
      rd = rnd();
      sample_valid <= 1'b1;
      sample <= {rd[23:0], rd[31:8]};
      @(posedge hclk);
      if (sample_ready === 1'b1) fifo_q.push_back(sample);
    end
    sample_valid <= 1'b0;
    chk_word(32'(fifo_q.size()), 32'h10);
    chk_word({31'h0, sample_ready}, 32'h0);
    rd_chk(32'(apr_pkg::REG_STATUS), {19'h0, 5'h10, 8'h00});
    ahb(1'b1, 32'(apr_pkg::REG_CTRL), 32'h1);
    fifo_q.delete();
    for (int k = 0; k < 40 && rd[12:8] !== 5'h0; k++) ahb(1'b0, 32'(apr_pkg::REG_STATUS), 32'h0);
    chk_word({27'h0, rd[12:8]}, 32'(fifo_q.size()));
    $display("Test buffer done");
    // Same stream with gain one and gain sixteen, reset in between
    rd = rnd();
    va = 24'h200000 | {3'h0, rd[20:0]};
    do_reset();
    send(512, 24'h001000, va);
    ahb(1'b0, 32'(apr_pkg::REG_POWER), 32'h0);
    p1 = rd;
    pins <= 4'h8;
    do_reset();
    send(512, 24'h001000, va);
    ahb(1'b0, 32'(apr_pkg::REG_POWER), 32'h0);
    p16 = rd;
    chk_span(p1, 32'h1, 32'h7FFF_FFFF);
    chk_span(p16, p1 * 15, p1 * 17);
    $display("Test gain done");
    // Full-scale in-phase power in the widest calibration ratio
    pins <= 4'h3;
    do_reset();
    send(3000, 24'h7FFFF0, 24'h7FFFF0);
    chk_span(32'(count_cf), 32'h1, 32'h3E8);
    chk_word(32'(width_cf), 32'(CF_W));
    rd_chk(32'(apr_pkg::REG_CF_CNT), 32'(count_cf));
    rd_chk(32'(apr_pkg::REG_SLOW_CNT), 32'(count_slow));
    ahb(1'b0, 32'(apr_pkg::REG_POWER), 32'h0);
    chk_word({31'h0, rd[31]}, 32'h0);
    // Clearing the tallies leaves run set
    ahb(1'b1, 32'(apr_pkg::REG_CTRL), 32'h3);
    rd_chk(32'(apr_pkg::REG_CF_CNT), 32'h0);
    rd_chk(32'(apr_pkg::REG_CTRL), 32'h1);
    $display("Test calibration pulses done");
    // Reversed power must not produce pulses
    do_reset();
    send(3000, 24'h7FFFF0, 24'h800010);
    chk_word(32'(count_cf), 32'h0);
    ahb(1'b0, 32'(apr_pkg::REG_POWER), 32'h0);
    chk_word({31'h0, rd[31]}, 32'h1);
    $display("Test reverse power done");
    wrap_up();
  end
endmodule
